/* File: hw/uvs_link_ctrl.v */
// ULPI link-side controller for supply, session request and power state.
// Assumes ULPI pins are synchronous to ref_clk; the bench resolves the data wire.
`timescale 1ns/1ps
`include "uvs_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module uvs_link_ctrl #(
  parameter PWRUP_MASK_CYC = `UVS_PWRUP_MASK_US * `UVS_CLK_MHZ
) (
  input wire ref_clk,
  input wire rstn,
  input wire ulpi_dir,
  input wire ulpi_nxt,
  input wire [7:0] ulpi_data_in,
  output reg [7:0] ulpi_data_out,
  output reg ulpi_data_oe,
  output reg ulpi_stp,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire fault_pol_invert,
  output reg op_ready,
  output reg op_done,
  output reg osc_clk_enable,
  output reg low_power,
  output reg supply_on,
  output reg supply_fault,
  output reg vbus_valid,
  output reg [1:0] vbus_state,
  output reg [7:0] rd_data
);

  localparam OSC_SETTLE_CYC = (`UVS_OSC_SETTLE_NS * `UVS_CLK_MHZ + 999) / 1000;

  localparam S_PWR = 4'd0;
  localparam S_IDLE = 4'd1;
  localparam S_FETCH = 4'd2;
  localparam S_TXCMD = 4'd3;
  localparam S_TXDAT = 4'd4;
  localparam S_STP = 4'd5;
  localparam S_RDCMD = 4'd6;
  localparam S_RDTA = 4'd7;
  localparam S_RDDAT = 4'd8;
  localparam S_SETTLE = 4'd9;
  localparam S_RESUME = 4'd10;

  // Step table: {kind, address, data}
  function [16:0] step_rom;
    input [2:0] op;
    input [2:0] step;
    input pol;
    begin
      step_rom = {`UVS_K_END, 6'h00, 8'h00};
      case ({op, step})
        {`UVS_OP_RESET, 3'd0}: step_rom = {`UVS_K_WR, `UVS_A_FC_SET, `UVS_FC_RESET};
        {`UVS_OP_SRP, 3'd0}: step_rom = {`UVS_K_WR, `UVS_A_OTG_CLR, `UVS_OTG_CHRG};
        {`UVS_OP_SRP, 3'd1}: step_rom = {`UVS_K_WR, `UVS_A_OTG_SET, `UVS_OTG_DISCHRG};
        {`UVS_OP_SRP, 3'd2}: step_rom = {`UVS_K_POLL, `UVS_A_IRQ_STAT, 8'h00};
        {`UVS_OP_SRP, 3'd3}: step_rom = {`UVS_K_WR, `UVS_A_OTG_CLR, `UVS_OTG_DISCHRG};
        {`UVS_OP_SRP, 3'd4}: step_rom = {`UVS_K_WR, `UVS_A_OTG_SET, `UVS_OTG_CHRG};
        {`UVS_OP_FAULT_CFG, 3'd0}: step_rom = {`UVS_K_WR, `UVS_A_OTG_SET, `UVS_OTG_EXT_IND};
        {`UVS_OP_FAULT_CFG, 3'd1}: step_rom = {`UVS_K_WR, (pol ? `UVS_A_IFC_SET : `UVS_A_IFC_CLR),
          `UVS_IFC_COMPL};
        {`UVS_OP_FAULT_CFG, 3'd2}: step_rom = {`UVS_K_WR, `UVS_A_IFC_SET, `UVS_IFC_PASS};
        {`UVS_OP_SUPPLY_ON, 3'd0}: step_rom = {`UVS_K_WR, `UVS_A_OTG_SET, `UVS_OTG_DRV_EXT};
        {`UVS_OP_SUPPLY_OFF, 3'd0}: step_rom = {`UVS_K_WR, `UVS_A_OTG_CLR, `UVS_OTG_DRV_EXT};
        {`UVS_OP_SUSPEND, 3'd0}: step_rom = {`UVS_K_WR, `UVS_A_FC_CLR, `UVS_FC_SUSPENDM};
        {`UVS_OP_SUSPEND, 3'd1}: step_rom = {`UVS_K_STOPCLK, 6'h00, 8'h00};
        {`UVS_OP_RESUME, 3'd0}: step_rom = {`UVS_K_RESUME, 6'h00, 8'h00};
        default: step_rom = {`UVS_K_END, 6'h00, 8'h00};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  reg [3:0] state_reg;
  reg [2:0] op_reg;
  reg [2:0] step_reg;
  reg pol_reg;
  reg dir_q_reg;
  reg off_pend_reg;
  reg [16:0] pwr_cnt_reg;
  reg [7:0] wdata_reg;
  reg [7:0] settle_cnt_reg;

  wire [16:0] cur = step_rom(op_reg, step_reg, pol_reg);
  wire [2:0] cur_kind = cur[16:14];
  // Bus is usable only once direction has been low for a full cycle
  wire bus_free = !ulpi_dir && !dir_q_reg;
  // Status byte: device owns bus for a settled cycle, not a read answer
  // Low power and start-up hold dir high with no status on the lines
  wire rx_status = ulpi_dir && dir_q_reg && !ulpi_nxt && !low_power &&
    (state_reg != S_RDDAT) && (state_reg != S_PWR);
  wire pwr_masked = (pwr_cnt_reg != 17'd0);

  always @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg <= S_PWR;
      op_reg <= `UVS_OP_RESET;
      step_reg <= 3'd0;
      pol_reg <= 1'b0;
      dir_q_reg <= 1'b0;
      off_pend_reg <= 1'b0;
      pwr_cnt_reg <= PWRUP_MASK_CYC[16:0];
      wdata_reg <= 8'h00;
      settle_cnt_reg <= 8'h00;
      ulpi_data_out <= 8'h00;
      ulpi_data_oe <= 1'b0;
      ulpi_stp <= 1'b0;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      osc_clk_enable <= 1'b1;
      low_power <= 1'b0;
      supply_on <= 1'b0;
      supply_fault <= 1'b0;
      vbus_valid <= 1'b0;
      vbus_state <= 2'b00;
      rd_data <= 8'h00;
    end else begin
      dir_q_reg <= ulpi_dir;
      op_done <= 1'b0;
      if (pwr_masked)
        pwr_cnt_reg <= pwr_cnt_reg - 17'd1;
      // Registered enable lags dir by a cycle, which falls in the turnaround
      ulpi_data_oe <= !ulpi_dir && !low_power;
      if (rx_status) begin
        vbus_state <= ulpi_data_in[3:2];
        vbus_valid <= !pwr_masked && (ulpi_data_in[3:2] == `UVS_VBUS_OK);
        if (supply_on && (ulpi_data_in[3:2] != `UVS_VBUS_OK)) begin
          supply_fault <= 1'b1;
          off_pend_reg <= 1'b1;
        end
      end
      case (state_reg)
        S_PWR: begin
          // Device holds dir high during its own start-up
          ulpi_data_out <= 8'h00;
          if (bus_free)
            state_reg <= S_FETCH;
        end
        S_IDLE: begin
          ulpi_data_out <= 8'h00;
          op_ready <= 1'b1;
          if (off_pend_reg && !low_power) begin
            op_ready <= 1'b0;
            off_pend_reg <= 1'b0;
            op_reg <= `UVS_OP_SUPPLY_OFF;
            step_reg <= 3'd0;
            state_reg <= S_FETCH;
          end else if (op_valid && op_ready && (!low_power || op_code == `UVS_OP_RESUME)) begin
            op_ready <= 1'b0;
            op_reg <= op_code;
            pol_reg <= fault_pol_invert;
            step_reg <= 3'd0;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: begin
          ulpi_data_out <= 8'h00;
          case (cur_kind)
            `UVS_K_WR: if (bus_free) begin
              wdata_reg <= cur[7:0];
              ulpi_data_out <= {`UVS_TX_REGW, cur[13:8]};
              state_reg <= S_TXCMD;
            end
            `UVS_K_POLL: if (bus_free) begin
              ulpi_data_out <= {`UVS_TX_REGR, cur[13:8]};
              state_reg <= S_RDCMD;
            end
            `UVS_K_STOPCLK: begin
              low_power <= 1'b1;
              osc_clk_enable <= 1'b0;
              step_reg <= step_reg + 3'd1;
            end
            `UVS_K_RESUME: begin
              osc_clk_enable <= 1'b1;
              settle_cnt_reg <= OSC_SETTLE_CYC[7:0];
              state_reg <= S_SETTLE;
            end
            default: begin
              if (op_reg == `UVS_OP_SUPPLY_ON)
                supply_on <= 1'b1;
              if (op_reg == `UVS_OP_SUPPLY_OFF)
                supply_on <= 1'b0;
              if (op_reg == `UVS_OP_RESUME)
                low_power <= 1'b0;
              op_done <= 1'b1;
              state_reg <= S_IDLE;
            end
          endcase
        end
        S_TXCMD: begin
          if (ulpi_dir) begin
            // Device took the bus first; retry the same step later
            ulpi_data_out <= 8'h00;
            state_reg <= S_FETCH;
          end else if (ulpi_nxt) begin
            ulpi_data_out <= wdata_reg;
            state_reg <= S_TXDAT;
          end
        end
        S_TXDAT: if (ulpi_nxt) begin
          ulpi_data_out <= 8'h00;
          ulpi_stp <= 1'b1;
          state_reg <= S_STP;
        end
        S_STP: begin
          ulpi_stp <= 1'b0;
          step_reg <= step_reg + 3'd1;
          state_reg <= S_FETCH;
        end
        S_RDCMD: begin
          if (ulpi_dir) begin
            ulpi_data_out <= 8'h00;
            state_reg <= S_FETCH;
          end else if (ulpi_nxt) begin
            ulpi_data_out <= 8'h00;
            state_reg <= S_RDTA;
          end
        end
        S_RDTA: if (ulpi_dir)
          state_reg <= S_RDDAT;
        S_RDDAT: begin
          rd_data <= ulpi_data_in;
          if (ulpi_data_in[`UVS_SESSION_END_FLAG_BIT])
            step_reg <= step_reg + 3'd1;
          state_reg <= S_FETCH;
        end
        S_SETTLE: begin
          if (settle_cnt_reg == 8'h00)
            state_reg <= S_RESUME;
          else
            settle_cnt_reg <= settle_cnt_reg - 8'h01;
        end
        S_RESUME: begin
          // Hold stop until the device releases the bus
          ulpi_stp <= ulpi_dir;
          if (!ulpi_dir && ulpi_stp) begin
            step_reg <= step_reg + 3'd1;
            state_reg <= S_FETCH;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

/* File: common/uvs_defs.vh */
// Constants for the ULPI supply and session controller.
// Assumes the standard ULPI register map on the transceiver.
`ifndef UVS_DEFS_VH
`define UVS_DEFS_VH
// Clock and timing
`define UVS_CLK_MHZ 100
`define UVS_OSC_SETTLE_NS 1000
`define UVS_PWRUP_MASK_US 1000
// Command prefixes on the data bus
`define UVS_TX_REGW 2'b10
`define UVS_TX_REGR 2'b11
// Transceiver register addresses (set and clear aliases, plus interrupt status)
`define UVS_A_FC_SET 6'h05
`define UVS_A_FC_CLR 6'h06
`define UVS_A_IFC_SET 6'h08
`define UVS_A_IFC_CLR 6'h09
`define UVS_A_OTG_SET 6'h0b
`define UVS_A_OTG_CLR 6'h0c
`define UVS_A_IRQ_STAT 6'h13
// Field masks
`define UVS_FC_RESET 8'h20
`define UVS_FC_SUSPENDM 8'h40
`define UVS_OTG_DISCHRG 8'h08
`define UVS_OTG_CHRG 8'h10
`define UVS_OTG_DRV_EXT 8'h40
`define UVS_OTG_EXT_IND 8'h80
`define UVS_IFC_COMPL 8'h20
`define UVS_IFC_PASS 8'h40
`define UVS_SESSION_END_FLAG_BIT 3
`define UVS_VBUS_OK 2'b11
// User operations
`define UVS_OP_RESET 3'd0
`define UVS_OP_SRP 3'd1
`define UVS_OP_FAULT_CFG 3'd2
`define UVS_OP_SUPPLY_ON 3'd3
`define UVS_OP_SUPPLY_OFF 3'd4
`define UVS_OP_SUSPEND 3'd5
`define UVS_OP_RESUME 3'd6
// Step kinds
`define UVS_K_END 3'd0
`define UVS_K_WR 3'd1
`define UVS_K_POLL 3'd2
`define UVS_K_STOPCLK 3'd3
`define UVS_K_RESUME 3'd4
`endif

/* File: tb/uvs_link_monitor.sv */
// Checker for the ULPI link controller ports.
// Assumes bind onto uvs_link_ctrl; one clock domain.
`timescale 1ns/1ps
module uvs_link_chk (
  input wire ref_clk,
  input wire rstn,
  input wire ulpi_dir,
  input wire ulpi_nxt,
  input wire [7:0] ulpi_data_out,
  input wire ulpi_data_oe,
  input wire ulpi_stp,
  input wire op_ready,
  input wire osc_clk_enable,
  input wire low_power,
  input wire supply_on,
  input wire supply_fault,
  input wire vbus_valid,
  input wire [1:0] vbus_state
);
  reg stp_seen_reg;
  wire tx_wait = ulpi_data_oe && !ulpi_dir && !ulpi_nxt && ulpi_data_out != 8'h00;
  always @(posedge ref_clk) begin
    if (!rstn) stp_seen_reg <= 1'b0;
    else if (ulpi_stp) stp_seen_reg <= 1'b1;
  end
  //////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr_end;
    ulpi_stp && ulpi_data_out == 8'h00 ##1 !ulpi_stp;
  endsequence
  chk_idle_low: assert property (op_ready && ulpi_data_oe |-> ulpi_data_out == 8'h00)
    else $error("data not low while idle");
  chk_reset_first: assert property (op_ready |-> stp_seen_reg)
    else $error("ready before reset command");
  chk_write_end: assert property (ulpi_stp && !low_power |-> s_wr_end)
    else $error("stop pulse wrong");
  chk_txcmd_hold: assert property (tx_wait |=> $stable(ulpi_data_out))
    else $error("byte changed before accept");
  chk_turn_around: assert property (ulpi_dir |=> !ulpi_data_oe)
    else $error("driving after direction change");
  chk_osc_lp: assert property (!osc_clk_enable |-> low_power)
    else $error("clock stopped outside low power");
  chk_osc_before: assert property ($fell(low_power) |-> $past(osc_clk_enable, 2))
    else $error("low power left without clock");
  chk_fault_off: assert property ($rose(supply_fault) |-> ##[1:40] !supply_on)
    else $error("supply kept on after fault");
  chk_valid_state: assert property (vbus_valid |-> vbus_state == 2'b11)
    else $error("valid without good state");
endmodule
bind uvs_link_ctrl uvs_link_chk u_chk (.ref_clk, .rstn, .ulpi_dir, .ulpi_nxt, .ulpi_data_out, .ulpi_data_oe,
  .ulpi_stp, .op_ready, .osc_clk_enable, .low_power, .supply_on, .supply_fault, .vbus_valid, .vbus_state);

/* File: tb/uvs_phy_model.sv */
// Behavioural transceiver on the ULPI side.
// Assumes the bench resolves the data wire with pull-downs.
`timescale 1ns/1ps
module uvs_phy_model (
  input wire ref_clk, // Stands in for the PLL-derived interface clock
  input wire ulpi_stp,
  input wire [7:0] ulpi_data_in,
  input wire rx_req,
  input wire [7:0] rx_byte,
  output reg ulpi_dir,
  output reg ulpi_nxt,
  output reg phy_oe,
  output reg [7:0] phy_data
);
  reg [7:0] fc, ifc, otg, wd;
  reg [5:0] ad;
  reg [3:0] st;
  reg lp, both;
  integer dcnt;
  //////////////////////////////////////////
  initial begin // Own power-on reset; ext indicator off
    {ulpi_dir, ulpi_nxt, phy_oe, lp, both} = 5'h00;
    {fc, ifc, otg, wd, phy_data} = 40'h0;
    ad = 6'h00;
    st = 4'h0;
    dcnt = 0;
  end
  always @(posedge ref_clk) begin
    both <= both | (otg[3] & otg[4]);
    case (st)
      0: if (lp) begin
        if (ulpi_stp) {ulpi_dir, lp} <= 2'b00;
      end else if (rx_req) begin
        ulpi_dir <= 1'b1; // Status after turnaround
        st <= 7;
      end else if (ulpi_data_in[7]) begin
        ad <= ulpi_data_in[5:0];
        ulpi_nxt <= 1'b1;
        st <= ulpi_data_in[6] ? 4 : 1;
      end
      1: st <= 2;
      2: begin
        wd <= ulpi_data_in;
        ulpi_nxt <= 1'b0;
        st <= 3;
      end
      3: if (ulpi_stp) begin
        st <= 0;
        case (ad)
          6'h05: fc <= fc | wd;
          6'h06: {fc, lp, ulpi_dir} <= {fc & ~wd, wd[6], wd[6]}; // Suspend blocks the bus
          6'h08: ifc <= ifc | wd;
          6'h09: ifc <= ifc & ~wd;
          6'h0b: otg <= otg | wd;
          6'h0c: otg <= otg & ~wd;
          default: ;
        endcase
      end
      4: {ulpi_nxt, ulpi_dir, st} <= {2'b01, 4'h5};
      5: begin
        phy_oe <= 1'b1;
        phy_data <= {4'h0, dcnt > 1, 3'h0}; // Session end after polls
        dcnt <= dcnt + otg[3];
        st <= 6;
      end
      7: {phy_oe, phy_data, st} <= {1'b1, rx_byte, 4'h8};
      default: {ulpi_dir, phy_oe, st} <= 6'h00;
    endcase
  end
endmodule

/* File: tb/tb.sv */
// Bench for the ULPI supply and session controller.
// Assumes the transceiver model drives dir, nxt and status.
`timescale 1ns/1ps
module tb;
  reg ref_clk = 0, rstn = 0, op_valid = 0, fault_pol_invert = 0, rx_req = 0;
  reg [2:0] op_code = 0;
  reg [7:0] rx_byte = 0;
  wire ulpi_dir, ulpi_nxt, ulpi_stp, ulpi_data_oe, phy_oe, op_ready, op_done, osc_clk_enable;
  wire low_power, supply_on, supply_fault, vbus_valid;
  wire [7:0] ulpi_data_out, phy_data, rd_data;
  wire [1:0] vbus_state;
  integer errors = 0, num_checks = 0, n, k;
  wire [7:0] ulpi_data_in = ulpi_data_oe ? ulpi_data_out : phy_oe ? phy_data : 8'h00;
  always #5 ref_clk = ~ref_clk;
  uvs_link_ctrl #(.PWRUP_MASK_CYC(50)) i_dut (.ref_clk, .rstn, .ulpi_dir, .ulpi_nxt, .ulpi_data_in,
    .ulpi_data_out, .ulpi_data_oe, .ulpi_stp, .op_valid, .op_code, .fault_pol_invert, .op_ready, .op_done,
    .osc_clk_enable, .low_power, .supply_on, .supply_fault, .vbus_valid, .vbus_state, .rd_data);
  uvs_phy_model i_phy (.ref_clk, .ulpi_stp, .ulpi_data_in, .rx_req, .rx_byte, .ulpi_dir, .ulpi_nxt,
    .phy_oe, .phy_data);
  //////////////////////////////////////////
  task check(input string name, input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wait_ready;
    begin
      for (n = 0; op_ready !== 1'b1 && n < 500; n = n + 1) @(negedge ref_clk);
      if (op_ready !== 1'b1) errors = errors + 1;
    end
  endtask
  task run_op(input [2:0] c, input p);
    begin
      wait_ready;
      @(posedge ref_clk);
      {op_valid, op_code, fault_pol_invert} <= {1'b1, c, p};
      @(posedge ref_clk);
      op_valid <= 1'b0;
      for (n = 0; op_done !== 1'b1 && n < 500; n = n + 1) @(negedge ref_clk);
      if (op_done !== 1'b1) errors = errors + 1;
    end
  endtask
  task status(input [7:0] b);
    begin
      @(posedge ref_clk);
      {rx_req, rx_byte} <= {1'b1, b};
      @(posedge ref_clk);
      rx_req <= 1'b0;
      repeat (6) @(negedge ref_clk);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  //////////////////////////////////////////
  initial begin
    #100000;
    errors = errors + 1;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_ready;
    check("reset addr", {2'b00, i_phy.ad}, 8'h05);
    check("reset data", i_phy.wd, 8'h20);
    status(8'h0c);
    check("masked valid", vbus_valid, 8'h00);
    check("vbus state", vbus_state, 8'h03);
    $display("test reset done");
    run_op(3'd1, 1'b0);
    check("session end", rd_data & 8'h08, 8'h08);
    check("charge only", i_phy.otg & 8'h18, 8'h10);
    check("no overlap", i_phy.both, 8'h00);
    $display("test session done");
    for (k = 1; k >= 0; k = k - 1) begin
      run_op(3'd2, k);
      check("ind cfg", i_phy.ifc & 8'h60, k ? 8'h60 : 8'h40);
      check("ext sel", i_phy.otg & 8'h80, 8'h80);
    end
    $display("test fault cfg done");
    run_op(3'd3, 1'b0);
    check("supply", i_phy.otg & 8'h40, 8'h40);
    status(8'h0c);
    check("valid", vbus_valid, 8'h01);
    status(8'h04);
    check("fault", supply_fault, 8'h01);
    for (n = 0; supply_on !== 1'b0 && n < 100; n = n + 1) @(negedge ref_clk);
    if (supply_on !== 1'b0) errors = errors + 1;
    wait_ready;
    check("supply off", i_phy.otg & 8'h40, 8'h00);
    $display("test overcurrent done");
    run_op(3'd5, 1'b0);
    check("low power", {low_power, osc_clk_enable, i_phy.lp}, 8'h05);
    check("lp state", vbus_state, 8'h01);
    run_op(3'd6, 1'b0);
    check("awake", {low_power, osc_clk_enable, i_phy.lp}, 8'h02);
    $display("test power done");
    run_op(3'd3, 1'b0);
    run_op(3'd4, 1'b0);
    check("user off", {supply_on, i_phy.otg[6]}, 8'h00);
    run_op(3'd0, 1'b0);
    check("reset cmd", {2'b00, i_phy.ad}, 8'h05);
    run_op(3'd3, 1'b0);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_ready;
    check("rerun reset", {2'b00, i_phy.ad}, 8'h05);
    check("fault cleared", {supply_on, supply_fault}, 8'h00);
    $display("test rerun done");
    complete_run;
  end
endmodule
